// ===== rtl/brs_pkg.sv
package brs_pkg;
   // Supply monitor build variant
   typedef enum logic [1:0] {
      BRS_HIGH,
      BRS_LOW,
      BRS_OFF
   } brs_variant_type;

   // Oscillator rate used to size both countdowns
   localparam int CLK_HZ  = 100000000;
   localparam int CLK_MHZ = CLK_HZ / 1000000;

   // Times in microseconds, as printed (low end of each preset range)
   localparam int TD_US      = 3000;
   localparam int REL_HI_US  = 120;
   localparam int REL_LO_US  = 360;

   // Cycle counts derived from the rate; whole microseconds give exact counts
   localparam int TD_CYCLES     = TD_US * CLK_MHZ;
   localparam int REL_HI_CYCLES = REL_HI_US * CLK_MHZ;
   localparam int REL_LO_CYCLES = REL_LO_US * CLK_MHZ;

   // Counter width holds the longest count (300000)
   localparam int CNT_W = 19;

   // Reset values
   localparam logic [CNT_W-1:0] CNT_RESET  = 19'h00000;
   localparam logic [1:0]       SYNC_RESET = 2'h0;
   localparam logic [1:0]       RST_HOLD   = 2'h3;
endpackage

// ===== rtl/brs_cnt_if.sv
`timescale 1ns/1ps
interface brs_cnt_if;
   logic                        load;
   logic                        en;
   logic [brs_pkg::CNT_W-1:0]   preset;
   logic [brs_pkg::CNT_W-1:0]   value;
   logic                        zero;

   modport ctl (output load, output en, output preset, input value, input zero);
   modport cnt (input load, input en, input preset, output value, output zero);
endinterface

// ===== rtl/brs_countdown.sv
`timescale 1ns/1ps
module brs_countdown (
   input wire logic clk,
   input wire logic rst,
   brs_cnt_if.cnt   cif
);
   logic [brs_pkg::CNT_W-1:0] value;
   logic [brs_pkg::CNT_W-1:0] next_value;

   // Load wins over counting; stops at zero so underflow never wraps
   always_comb begin
      next_value = value;
      if (cif.load) begin
         next_value = cif.preset;
      end else if (cif.en && (value != brs_pkg::CNT_RESET)) begin
         next_value = value - brs_pkg::CNT_W'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         value <= brs_pkg::CNT_RESET;
      end else begin
         value <= next_value;
      end
   end

   assign cif.value = value;
   assign cif.zero  = (value == brs_pkg::CNT_RESET);

   // Counting steps down by exactly one per enabled cycle
   AST_CNT_STEP: assert property (@(posedge clk) disable iff (rst) // (R13)
      (!cif.load && cif.en && !cif.zero) |=> (value == $past(value) - brs_pkg::CNT_W'(1)))
      else $error("countdown did not step by one");
endmodule

// ===== rtl/brs_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// (R1) Pin low 0.5/1.5 us guarantees init
// (R2) Unmonitored parts: pin held through ramp
// (R3) Below threshold: reset, preset release countdown
// (R4) Hold reset until countdown reaches zero
// (R5) Monitor reset acts like pin reset
// (R6) Threshold regained: countdown restarts from preset
// (R7) Above trigger: 3 ms delay, reset held
// (R8) Countdown needs delay expired and threshold
// (R9) Shallow dip: countdown on recovery, no delay
// (R10) Monitor active from power-on, holds reset
// (R11) After underflow no resets while above threshold
// (R12) Disabled variant makes no internal resets
// (R13) Counters sized from clock rate
// (R14) Async assert, two-stage synchronous release
module brs_sequencer #(
   parameter brs_pkg::brs_variant_type VARIANT       = brs_pkg::BRS_HIGH,
   parameter int                       TD_CYCLES     = brs_pkg::TD_CYCLES,
   parameter int                       REL_HI_CYCLES = brs_pkg::REL_HI_CYCLES,
   parameter int                       REL_LO_CYCLES = brs_pkg::REL_LO_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ext_reset_n,
   input  wire logic supply_above_trigger,
   input  wire logic supply_above_bor,
   output logic      sys_rst,
   output logic      bor_hold
);
   typedef enum logic [2:0] {
      S_LOW,
      S_DELAY,
      S_WAIT,
      S_COUNT,
      S_RUN
   } brs_state_type;

   localparam int REL_CYCLES = (VARIANT == brs_pkg::BRS_LOW) ? REL_LO_CYCLES : REL_HI_CYCLES;

   // Disabled build never raises a hold, not even while power-on reset is high
   localparam logic HOLD_AT_RESET = (VARIANT != brs_pkg::BRS_OFF);

   brs_state_type state;
   brs_state_type next_state;
   logic          next_bor_hold;
   logic [1:0]    trig_sync;
   logic [1:0]    next_trig_sync;
   logic [1:0]    bor_sync;
   logic [1:0]    next_bor_sync;
   logic [1:0]    rst_sync;
   logic [1:0]    next_rst_sync;
   logic          above_trig;
   logic          above_bor;
   logic          async_rst;

   brs_cnt_if td_if ();
   brs_cnt_if rel_if ();

   brs_countdown u_trigger_delay (
      .clk (clk),
      .rst (rst),
      .cif (td_if)
   );

   brs_countdown u_release_countdown (
      .clk (clk),
      .rst (rst),
      .cif (rel_if)
   );

   // Comparators are analog and asynchronous: two flops before use
   always_comb begin
      next_trig_sync = {trig_sync[0], supply_above_trigger};
      next_bor_sync  = {bor_sync[0], supply_above_bor};
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trig_sync <= brs_pkg::SYNC_RESET;
         bor_sync  <= brs_pkg::SYNC_RESET;
      end else begin
         trig_sync <= next_trig_sync;
         bor_sync  <= next_bor_sync;
      end
   end

   assign above_trig = trig_sync[1];
   assign above_bor  = bor_sync[1];

   assign td_if.preset  = brs_pkg::CNT_W'(TD_CYCLES);  // (R13)
   assign rel_if.preset = brs_pkg::CNT_W'(REL_CYCLES); // (R13)

   // Monitor sequence; a trigger loss overrides every state
   always_comb begin
      next_state  = state;
      td_if.load  = 1'b0;
      td_if.en    = 1'b0;
      rel_if.load = 1'b0;
      rel_if.en   = 1'b0;
      unique case (state)
         S_LOW: begin
            td_if.load  = 1'b1;
            rel_if.load = 1'b1;
            if (above_trig) begin
               next_state = S_DELAY; // (R7)
            end
         end
         S_DELAY: begin
            td_if.en    = 1'b1; // (R7)
            rel_if.load = 1'b1;
            if (td_if.zero) begin
               next_state = S_WAIT;
            end
         end
         S_WAIT: begin
            rel_if.load = 1'b1; // (R3)
            if (above_bor) begin
               next_state = S_COUNT; // (R6) (R8) (R9)
            end
         end
         S_COUNT: begin
            if (!above_bor) begin
               next_state = S_WAIT; // (R3)
            end else if (rel_if.zero) begin
               next_state = S_RUN; // (R4)
            end else begin
               rel_if.en = 1'b1;
            end
         end
         S_RUN: begin
            if (!above_bor) begin
               next_state = S_WAIT; // (R3) (R11)
            end
         end
      endcase
      if (!above_trig) begin
         next_state = S_LOW; // (R7)
      end
      // Disabled variant never requests a reset
      next_bor_hold = (VARIANT != brs_pkg::BRS_OFF) && (next_state != S_RUN); // (R4) (R12)
   end

   // Power-on reset starts the monitor in its holding state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state    <= S_LOW;   // (R10)
         bor_hold <= HOLD_AT_RESET; // (R10) (R12)
      end else begin
         state    <= next_state;
         bor_hold <= next_bor_hold;
      end
   end

   // Power-on, pin or monitor hold forces reset at once; release waits two clean edges
   assign async_rst = rst | ~ext_reset_n | bor_hold; // (R5) (R14)

   always_comb begin
      next_rst_sync = {rst_sync[0], 1'b0};
   end

   always_ff @(posedge clk or posedge async_rst) begin
      if (async_rst) begin
         rst_sync <= brs_pkg::RST_HOLD; // (R14)
      end else begin
         rst_sync <= next_rst_sync;
      end
   end

   assign sys_rst = rst_sync[1];

   // Sampled-value checks; all of them pause while power-on reset is high
   AST_DROP_HOLDS: assert property (@(posedge clk) disable iff (rst) // (R3)
      ($fell(above_bor) && (VARIANT != brs_pkg::BRS_OFF)) |=> bor_hold)
      else $error("threshold loss did not assert reset");

   AST_RELEASE_AT_ZERO: assert property (@(posedge clk) disable iff (rst) // (R4)
      $fell(bor_hold) |-> ($past(state) == S_COUNT) && $past(rel_if.zero))
      else $error("reset released before countdown reached zero");

   AST_SAME_EFFECT: assert property (@(posedge clk) disable iff (rst) // (R5)
      (bor_hold || !ext_reset_n) |-> sys_rst)
      else $error("reset source not seen on internal reset");

   AST_RESTART: assert property (@(posedge clk) disable iff (rst) // (R6)
      (state == S_WAIT && above_bor && above_trig) |=>
         (state == S_COUNT) && (rel_if.value == rel_if.preset))
      else $error("countdown not restarted from preset");

   AST_DELAY_START: assert property (@(posedge clk) disable iff (rst) // (R7)
      (state == S_LOW && above_trig) |=> (state == S_DELAY) && (td_if.value == td_if.preset))
      else $error("trigger delay not started");

   AST_COUNT_GATED: assert property (@(posedge clk) disable iff (rst) // (R8)
      rel_if.en |-> td_if.zero && above_bor && (state == S_COUNT))
      else $error("countdown ran before delay expired");

   // A shallow dip keeps the expired delay, so recovery goes straight to counting
   AST_SHALLOW_DIP: assert property (@(posedge clk) disable iff (rst) // (R9)
      (state == S_RUN && !above_bor && above_trig) |=>
         (state == S_WAIT) && td_if.zero)
      else $error("shallow dip re-armed the trigger delay");

   // Losing the trigger level re-arms the full delay, with reset held except in the disabled build
   AST_TRIG_LOSS: assert property (@(posedge clk) disable iff (rst) // (R7)
      (!above_trig && (VARIANT != brs_pkg::BRS_OFF)) |=> (state == S_LOW) && bor_hold)
      else $error("trigger loss did not re-arm the delay");

   AST_POWER_ON: assert property (@(posedge clk) disable iff (rst) // (R10)
      $past(rst) |-> sys_rst && (bor_hold || (VARIANT == brs_pkg::BRS_OFF)))
      else $error("reset not held after power-on");

   AST_NO_EXTRA: assert property (@(posedge clk) disable iff (rst) // (R11)
      (state == S_RUN && above_bor && above_trig) |=> !bor_hold)
      else $error("spurious internal reset");

   AST_DISABLED: assert property (@(posedge clk) disable iff (rst) // (R12)
      (VARIANT == brs_pkg::BRS_OFF) |-> !bor_hold)
      else $error("disabled monitor produced reset");

   AST_SYNC_RELEASE: assert property (@(posedge clk) disable iff (rst) // (R14)
      $fell(sys_rst) |-> !$past(async_rst) && !$past(async_rst, 2))
      else $error("reset released without two clean edges");
endmodule

// ===== verification/brs_supply_model.sv
`timescale 1ns/1ps
// Far side: supply comparators plus the external reset circuit
module brs_supply_model #(
   parameter int PIN_MIN = 150
) (
   input  wire logic       clk,
   input  wire logic [1:0] level,
   input  wire logic       pin_req,
   output logic            ext_reset_n,
   output logic            supply_above_trigger,
   output logic            supply_above_bor
);
   int hold_cnt = 0;
   // Level 0 below trigger, 1 between trigger and threshold, 2 in range
   assign supply_above_trigger = (level != 2'h0);
   assign supply_above_bor     = (level == 2'h2);
   // Short requests are stretched, since a narrow pulse may not initialise
   always @(posedge clk) begin
      if (pin_req) hold_cnt <= PIN_MIN;
      else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
   end
   // Pin also held low while the supply is below trigger (level 0)
   assign ext_reset_n = !(pin_req || hold_cnt > 0 || level == 2'h0);
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   typedef struct {
      logic [1:0] lv;
      logic       pin;
      int         wt;
      logic       hold;
      logic       srst;
      logic       osrst;
      logic       hhold;
      logic       hsrst;
   } brs_tb_row_type;
   logic       clk;
   logic       rst;
   logic [1:0] level;
   logic       pin_req;
   logic       ext_reset_n;
   logic       trig;
   logic       bor;
   logic       sys_rst;
   logic       bor_hold;
   logic       off_rst;
   logic       off_hold;
   logic       hi_rst;
   logic       hi_hold;
   int         error_cnt = 0;
   int         samples_checked = 0;
   int         cyc = 0;
   // Short counts: delay 20; countdown 30 low build, 10 high build
   // Disabled build keeps default counts, since it never counts for a hold
   brs_tb_row_type rows[12] = '{
      '{2'h2, 1'b0, 10, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
      '{2'h2, 1'b0, 35, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
      '{2'h2, 1'b0, 20, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
      '{2'h1, 1'b0, 5, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
      '{2'h2, 1'b0, 22, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
      '{2'h2, 1'b0, 20, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
      '{2'h0, 1'b0, 5, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1},
      '{2'h1, 1'b0, 40, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
      '{2'h2, 1'b0, 22, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
      '{2'h2, 1'b0, 20, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
      '{2'h2, 1'b1, 3, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1},
      '{2'h2, 1'b0, 160, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}};
   brs_supply_model far_u (.clk(clk), .level(level), .pin_req(pin_req),
      .ext_reset_n(ext_reset_n), .supply_above_trigger(trig), .supply_above_bor(bor));
   brs_sequencer #(.VARIANT(brs_pkg::BRS_LOW), .TD_CYCLES(20), .REL_HI_CYCLES(10),
      .REL_LO_CYCLES(30)) dut_u (.clk(clk), .rst(rst), .ext_reset_n(ext_reset_n),
      .supply_above_trigger(trig), .supply_above_bor(bor), .sys_rst(sys_rst),
      .bor_hold(bor_hold));
   brs_sequencer #(.VARIANT(brs_pkg::BRS_OFF)) dut_off_u (.clk(clk), .rst(rst),
      .ext_reset_n(ext_reset_n), .supply_above_trigger(trig), .supply_above_bor(bor),
      .sys_rst(off_rst), .bor_hold(off_hold));
   // High-threshold build uses the shorter release countdown
   brs_sequencer #(.VARIANT(brs_pkg::BRS_HIGH), .TD_CYCLES(20), .REL_HI_CYCLES(10)) dut_hi_u (
      .clk(clk), .rst(rst), .ext_reset_n(ext_reset_n), .supply_above_trigger(trig),
      .supply_above_bor(bor), .sys_rst(hi_rst), .bor_hold(hi_hold));
   // Single-bit comparison, counted either way
   task automatic chk(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d errors=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Run is about 610 cycles; a hang stops well short of anything long
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt++;
         conclude();
      end
   end
   initial begin
      rst = 1'b1;
      level = 2'h2;
      pin_req = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // Power-up, shallow dip, deep dip, then the pin
      foreach (rows[i]) begin
         level <= rows[i].lv;
         pin_req <= rows[i].pin;
         repeat (rows[i].wt) @(posedge clk);
         #1;
         chk(bor_hold, rows[i].hold);
         chk(sys_rst, rows[i].srst);
         chk(off_rst, rows[i].osrst);
         chk(off_hold, 1'b0);
         chk(hi_hold, rows[i].hhold);
         chk(hi_rst, rows[i].hsrst);
         @(posedge clk);
      end
      // Pin assertion reaches the output before any clock edge
      pin_req <= 1'b1;
      #2;
      chk(sys_rst, 1'b1);
      chk(off_rst, 1'b1);
      @(posedge clk);
      pin_req <= 1'b0;
      repeat (160) @(posedge clk);
      // Reset in mid-run: monitor restarts from the full delay
      rst <= 1'b1;
      #2;
      chk(sys_rst, 1'b1);
      chk(bor_hold, 1'b1);
      chk(off_hold, 1'b0);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (30) @(posedge clk);
      #1;
      chk(bor_hold, 1'b1);
      chk(hi_hold, 1'b1);
      repeat (40) @(posedge clk);
      #1;
      chk(bor_hold, 1'b0);
      chk(hi_hold, 1'b0);
      chk(hi_rst, 1'b0);
      chk(sys_rst, 1'b0);
      conclude();
   end
endmodule
